// ==== hw/charger_config_registers.sv ====
// charger configuration bank with its two-wire serial target port
// assumes the serial pins and charge pin are asynchronous to core_clk
`timescale 1ns/1ps
module charger_config_registers #(
  parameter int unsigned CYCLES_PER_MIN = charger_cfg_pkg::MIN_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // serial target pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // device inputs
  input wire logic chargePinN,
  input wire logic regReset,
  input wire logic watchdogExpired,
  input wire logic termMet,
  input wire logic [4:0] inputLimitCode,
  // control outputs
  output logic chargeEnable,
  output logic boostEnable,
  output logic chargeDone,
  output logic watchdogKick,
  output logic lightLoadDisable,
  output logic inputSwitchHighRes,
  output logic rechargeSel,
  // decoded settings
  output logic [charger_cfg_pkg::MV_W-1:0] ichgMa,
  output logic [charger_cfg_pkg::MV_W-1:0] preMa,
  output logic [charger_cfg_pkg::MV_W-1:0] termMa,
  output logic [charger_cfg_pkg::MV_W-1:0] vregMv,
  output logic [charger_cfg_pkg::MV_W-1:0] sysMinMv,
  output logic [charger_cfg_pkg::MV_W-1:0] batFallMv,
  output logic [charger_cfg_pkg::MV_W-1:0] batRiseMv,
  output logic [charger_cfg_pkg::MV_W-1:0] boostLimMa
);
  import charger_cfg_pkg::*;

  // unpacked so that each generated process owns one whole word
  logic [7:0] regFile [REG_COUNT];
  logic sclMeta_reg;
  logic sclSync_reg;
  logic sclLast_reg;
  logic sdaMeta_reg;
  logic sdaSync_reg;
  logic sdaLast_reg;
  logic ceMeta_reg;
  logic ceSync_reg;
  logic sclRise;
  logic sclFall;
  logic busStart;
  logic busStop;
  link_state_t state_reg;
  logic ackPhase_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shifter_reg;
  logic [7:0] regAddr_reg;
  logic [7:0] rdByte;
  logic wrStb_reg;
  logic [7:0] wrAddr_reg;
  logic [7:0] wrData_reg;
  logic [MV_W-1:0] ichgD;
  logic [MV_W-1:0] preD;
  logic [MV_W-1:0] termD;
  logic [MV_W-1:0] vregD;
  logic [MV_W-1:0] sysMinD;
  logic [MV_W-1:0] batFallD;
  logic [MV_W-1:0] boostLimD;

  topoff_if tif ();

  function automatic logic inRange(input logic [7:0] a);
    return a >= REG_FIRST && a <= REG_LAST;
  endfunction

  // two flops on every pin; edges use the second flop and its copy
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sclLast_reg <= 1'b1;
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      sdaLast_reg <= 1'b1;
      ceMeta_reg <= 1'b1;
      ceSync_reg <= 1'b1;
    end else begin
      sclMeta_reg <= sclIn;
      sclSync_reg <= sclMeta_reg;
      sclLast_reg <= sclSync_reg;
      sdaMeta_reg <= sdaIn;
      sdaSync_reg <= sdaMeta_reg;
      sdaLast_reg <= sdaSync_reg;
      ceMeta_reg <= chargePinN;
      ceSync_reg <= ceMeta_reg;
    end
  end

  assign sclRise = sclSync_reg && !sclLast_reg;
  assign sclFall = !sclSync_reg && sclLast_reg;
  assign busStart = sclSync_reg && sclLast_reg && sdaLast_reg && !sdaSync_reg;
  assign busStop = sclSync_reg && sclLast_reg && !sdaLast_reg && sdaSync_reg;

  // outside the bank a read returns zero
  assign rdByte = inRange(regAddr_reg) ?
    regFile[2'(regAddr_reg - REG_FIRST)] : 8'h00;

  // serial target engine; the pin is only ever pulled low
  always_ff @(posedge core_clk) begin
    wrStb_reg <= 1'b0;
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      ackPhase_reg <= 1'b0;
      bitCnt_reg <= '0;
      shifter_reg <= '0;
      regAddr_reg <= '0;
      sdaOe <= 1'b0;
      wrAddr_reg <= '0;
      wrData_reg <= '0;
    end else if (busStart) begin
      state_reg <= ST_DEV;
      ackPhase_reg <= 1'b0;
      bitCnt_reg <= '0;
      sdaOe <= 1'b0;
    end else if (busStop) begin
      state_reg <= ST_IDLE;
      ackPhase_reg <= 1'b0;
      sdaOe <= 1'b0;
    end else if (state_reg != ST_IDLE) begin
      if (sclRise && !ackPhase_reg) begin
        shifter_reg <= {shifter_reg[6:0], sdaSync_reg};
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end else if (sclRise && state_reg == ST_RD && sdaSync_reg) begin
        state_reg <= ST_IDLE;
        ackPhase_reg <= 1'b0;
      end else if (sclFall && ackPhase_reg) begin
        ackPhase_reg <= 1'b0;
        bitCnt_reg <= '0;
        if (state_reg == ST_RD) begin
          shifter_reg <= rdByte;
          sdaOe <= ~rdByte[7];
          regAddr_reg <= regAddr_reg + 8'h01; // R17
        end else begin
          sdaOe <= 1'b0;
        end
      end else if (sclFall && bitCnt_reg == BYTE_BITS) begin
        ackPhase_reg <= 1'b1;
        case (state_reg)
          ST_DEV: begin
            if (shifter_reg[7:1] == DEV_ADDR) begin // R17
              sdaOe <= 1'b1;
              state_reg <= shifter_reg[0] ? ST_RD : ST_REG;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          ST_REG: begin
            if (inRange(shifter_reg)) begin
              sdaOe <= 1'b1;
              regAddr_reg <= shifter_reg;
              state_reg <= ST_WR;
            end else begin
              state_reg <= ST_IDLE; // R18
            end
          end
          ST_WR: begin
            if (inRange(regAddr_reg)) begin
              sdaOe <= 1'b1;
              wrStb_reg <= 1'b1;
              wrAddr_reg <= regAddr_reg;
              wrData_reg <= shifter_reg;
              regAddr_reg <= regAddr_reg + 8'h01; // R17
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          ST_RD: sdaOe <= 1'b0;
          default: state_reg <= ST_IDLE;
        endcase
      end else if (sclFall && state_reg == ST_RD) begin
        sdaOe <= ~shifter_reg[7];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    sdaOut <= 1'b0;
  end

  // watchdog wins over a write landing in the same cycle
  for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
    always_ff @(posedge core_clk) begin
      if (sys_rst || regReset) begin
        regFile[i] <= REG_DEFAULT[i]; // R16
      end else if (watchdogExpired) begin
        regFile[i] <= (regFile[i] & ~WD_MASK[i]) // R16
          | (REG_DEFAULT[i] & WD_MASK[i]);
      end else if (wrStb_reg && wrAddr_reg == REG_FIRST + 8'(i)) begin
        regFile[i] <= wrData_reg & STORE_MASK[i]; // R1
      end
    end
  end

  // kick is a pulse; the stored bit is masked so it reads zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      watchdogKick <= 1'b0;
    end else begin
      watchdogKick <= wrStb_reg && wrAddr_reg == REG_FIRST // R1
        && wrData_reg[BIT_KICK];
    end
  end

  charger_cfg_decode u_decode (
    .ichgCode(regFile[1][5:0]),
    .preCode(regFile[2][7:4]),
    .termCode(regFile[2][3:0]),
    .vregCode(regFile[3][7:3]),
    .sysMinCode(regFile[0][3:1]),
    .batSel(regFile[0][BIT_BATSEL]),
    .boostLimSel(regFile[1][BIT_BLIM]),
    .ichgMa(ichgD),
    .preMa(preD),
    .termMa(termD),
    .vregMv(vregD),
    .sysMinMv(sysMinD),
    .batFallMv(batFallD),
    .boostLimMa(boostLimD)
  );

  assign tif.sel = regFile[3][2:1];
  assign tif.chargeOn = chargeEnable;
  assign tif.termMet = termMet;
  assign chargeDone = tif.done;

  post_termination_timer #(.CYCLES_PER_MIN(CYCLES_PER_MIN)) u_topoff (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tif(tif.timer)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      chargeEnable <= 1'b0;
      boostEnable <= 1'b0;
      lightLoadDisable <= 1'b0;
      inputSwitchHighRes <= 1'b0;
      rechargeSel <= 1'b0;
    end else begin
      boostEnable <= regFile[0][BIT_BOOST];
      chargeEnable <= !regFile[0][BIT_BOOST] // R2
        && regFile[0][BIT_CHG] && !ceSync_reg // R3
        && regFile[1][5:0] != 6'h00; // R9
      lightLoadDisable <= regFile[0][BIT_LIGHT];
      inputSwitchHighRes <= !regFile[0][BIT_BOOST] // R7
        && !regFile[1][BIT_FULL] && inputLimitCode < IIN_700_CODE;
      rechargeSel <= regFile[3][BIT_RECHG];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ichgMa <= '0;
      preMa <= '0;
      termMa <= '0;
      vregMv <= '0;
      sysMinMv <= '0;
      batFallMv <= '0;
      batRiseMv <= '0;
      boostLimMa <= '0;
    end else begin
      ichgMa <= ichgD;
      preMa <= preD;
      termMa <= termD;
      vregMv <= vregD;
      sysMinMv <= sysMinD;
      batFallMv <= batFallD;
      batRiseMv <= BAT_RISE_MV; // R5
      boostLimMa <= boostLimD;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence kickWrite;
    wrStb_reg && wrAddr_reg == REG_FIRST && wrData_reg[BIT_KICK];
  endsequence
  sequence kickPulse;
    watchdogKick ##1 !watchdogKick && !regFile[0][BIT_KICK];
  endsequence
  sequence regNack;
    state_reg == ST_REG && sclFall && !ackPhase_reg && !busStart
      && !busStop && bitCnt_reg == BYTE_BITS && !inRange(shifter_reg);
  endsequence

  AST_KICK_PULSE: assert property (kickWrite |=> kickPulse) // R1
    else $error("kick did not pulse once and self clear");
  AST_BOOST_BLOCKS: assert property ( // R2
    boostEnable |-> !chargeEnable)
    else $error("charging while boost enabled");
  AST_CE_PIN: assert property ( // R3
    chargeEnable |-> !$past(ceSync_reg) && $past(regFile[0][BIT_CHG]))
    else $error("charge enabled without pin low and bit set");
  AST_SYSMIN_DEF: assert property ( // R4
    regFile[0][3:1] == SYSMIN_DEF |=> sysMinMv == SYSMIN_DEF_MV)
    else $error("system minimum code 101 not 3.5 V");
  AST_SWITCH: assert property ( // R7
    regFile[0][BIT_BOOST] || regFile[1][BIT_FULL] |=> !inputSwitchHighRes)
    else $error("small input switch used when not allowed");
  AST_FAST_CHARGE_CURRENT_CLAMP: assert property (ichgMa <= FAST_CHARGE_CURRENT_TOP_MA) // R8
    else $error("fast charge current above clamp");
  AST_FAST_CHARGE_CURRENT_ZERO: assert property ( // R9
    regFile[1][5:0] == 6'h00 |=> !chargeEnable)
    else $error("charging with zero fast charge code");
  // outputs still hold the reset zero at the first edge after release
  AST_PRE_CLAMP: assert property ( // R10
    !$past(sys_rst) |-> preMa <= ITAP_TOP_MA && preMa >= CUR_LSB_MA)
    else $error("precharge current out of range");
  AST_TERM_CLAMP: assert property ( // R11
    !$past(sys_rst) |-> termMa <= ITAP_TOP_MA && termMa >= CUR_LSB_MA)
    else $error("termination current out of range");
  AST_CHARGE_VOLTAGE_LINEAR: assert property ( // R12
    regFile[3][7:3] < CHARGE_VOLTAGE_MAX && regFile[3][7:3] != CHARGE_VOLTAGE_SPECIAL
    |=> vregMv == CHARGE_VOLTAGE_BASE_MV + MV_W'($past(regFile[3][7:3])) * CHARGE_VOLTAGE_LSB_MV)
    else $error("charge voltage not linear");
  AST_CHARGE_VOLTAGE_SPECIAL: assert property ( // R13
    regFile[3][7:3] == CHARGE_VOLTAGE_SPECIAL |=> vregMv == CHARGE_VOLTAGE_SPECIAL_MV)
    else $error("special charge voltage code wrong");
  AST_CHARGE_VOLTAGE_CLAMP: assert property ( // R14
    regFile[3][7:3] >= CHARGE_VOLTAGE_MAX |=> vregMv == CHARGE_VOLTAGE_TOP_MV)
    else $error("charge voltage not clamped");
  AST_WD_RESTORE: assert property ( // R16
    watchdogExpired && !regReset |=> regFile[3] == REG_DEFAULT[3]
      && regFile[1][BIT_FULL] == $past(regFile[1][BIT_FULL]))
    else $error("watchdog restore wrong");
  AST_AUTO_INC: assert property ( // R17
    wrStb_reg |-> regAddr_reg == wrAddr_reg + 8'h01)
    else $error("address did not advance after write");
  AST_REG_NACK: assert property ( // R18
    regNack |=> state_reg == ST_IDLE && !sdaOe)
    else $error("undefined register acknowledged");
endmodule

// ==== hw/charger_cfg_pkg.sv ====
// constants, defaults and types for the charger configuration bank
// assumes one 20 MHz clock and a synchronous active-high reset
// Overview of operation
// R1 - writing one to the kick bit pulses watchdog restart; bit always reads zero
// R2 - boost output enable overrides charge enable; no charging while boosting
// R3 - charging needs the charge pin low and the charge enable bit set
// R4 - system minimum code selects 2.6 to 3.7 V; resets to 101
// R5 - boost battery bit picks 2.8 or 2.5 V falling; rising is 3.0 V
// R6 - boost limit bit picks 0.5 A or 1.2 A; resets to one
// R7 - switch bit zero uses small switch below 700 mA; ignored in boost
// R8 - fast charge code is 60 mA per step; resets 100010; clamps at 110010
// R9 - fast charge code zero disables charging
// R10 - precharge code is 60 mA per step plus 60 mA; clamps at 1100
// R11 - termination code is 60 mA per step plus 60 mA; clamps at 1100
// R12 - charge voltage is 3.856 V plus 32 mV per step up to 11000
// R13 - charge voltage resets to 01011; code 01111 means 4.352 V
// R14 - charge voltage codes above 11000 clamp to 11000, 4.624 V
// R15 - top-off code 00 stops at termination; else extends 15, 30, 45 minutes
// R16 - register reset restores all; watchdog expiry restores only its fields
// R17 - serial target at fixed address with auto-incrementing multi-byte access
// R18 - undefined register address is not acknowledged and engine returns idle
package charger_cfg_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h6B;
  localparam logic [7:0] REG_FIRST = 8'h01;
  localparam logic [7:0] REG_LAST = 8'h04;
  localparam int REG_COUNT = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // index 0 is the register at REG_FIRST
  localparam logic [7:0] REG_DEFAULT [REG_COUNT] =
    '{8'h1A, 8'hA2, 8'h22, 8'h58};
  localparam logic [7:0] WD_MASK [REG_COUNT] =
    '{8'h70, 8'hBF, 8'hFF, 8'hFF};
  localparam logic [7:0] STORE_MASK [REG_COUNT] =
    '{8'hBF, 8'hFF, 8'hFF, 8'hFF};
  localparam int BIT_LIGHT = 7;
  localparam int BIT_KICK = 6;
  localparam int BIT_BOOST = 5;
  localparam int BIT_CHG = 4;
  localparam int BIT_BATSEL = 0;
  localparam int BIT_BLIM = 7;
  localparam int BIT_FULL = 6;
  localparam int BIT_RECHG = 0;
  localparam int MV_W = 13;
  localparam logic [5:0] FAST_CHARGE_CURRENT_MAX = 6'h32;
  localparam logic [3:0] ITAP_MAX = 4'hC;
  localparam logic [4:0] CHARGE_VOLTAGE_MAX = 5'h18;
  localparam logic [4:0] CHARGE_VOLTAGE_SPECIAL = 5'h0F;
  localparam logic [4:0] IIN_700_CODE = 5'h06;
  localparam logic [MV_W-1:0] CUR_LSB_MA = 13'h003C;
  localparam logic [MV_W-1:0] CHARGE_VOLTAGE_BASE_MV = 13'h0F10;
  localparam logic [MV_W-1:0] CHARGE_VOLTAGE_LSB_MV = 13'h0020;
  localparam logic [MV_W-1:0] CHARGE_VOLTAGE_SPECIAL_MV = 13'h1100;
  localparam logic [MV_W-1:0] CHARGE_VOLTAGE_TOP_MV = 13'h1210;
  localparam logic [MV_W-1:0] BAT_FALL_HI_MV = 13'h0AF0;
  localparam logic [MV_W-1:0] BAT_FALL_LO_MV = 13'h09C4;
  localparam logic [MV_W-1:0] BAT_RISE_MV = 13'h0BB8;
  localparam logic [MV_W-1:0] BLIM_LO_MA = 13'h01F4;
  localparam logic [MV_W-1:0] BLIM_HI_MA = 13'h04B0;
  localparam logic [MV_W-1:0] FAST_CHARGE_CURRENT_TOP_MA = 13'h0BB8;
  localparam logic [MV_W-1:0] ITAP_TOP_MA = 13'h030C;
  localparam logic [MV_W-1:0] SYSMIN_MV [8] = '{13'h0A28, 13'h0AF0,
    13'h0BB8, 13'h0C80, 13'h0D48, 13'h0DAC, 13'h0E10, 13'h0E74};
  localparam logic [MV_W-1:0] SYSMIN_DEF_MV = 13'h0DAC;
  localparam logic [2:0] SYSMIN_DEF = 3'h5;
  localparam int CLK_HZ = 32'h0131_2D00;
  localparam int MINUTE_S = 32'h0000_003C;
  localparam int MIN_CYCLES = MINUTE_S * CLK_HZ;
  localparam logic [5:0] TOPOFF_STEP_MIN = 6'h0F;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_RD
  } link_state_t;
endpackage

// ==== hw/topoff_if.sv ====
// carries top-off timer control and completion between bank and timer
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface topoff_if;
  logic [1:0] sel;
  logic chargeOn;
  logic termMet;
  logic done;
  modport ctrl (output sel, output chargeOn, output termMet, input done);
  modport timer (input sel, input chargeOn, input termMet, output done);
endinterface

// ==== hw/post_termination_timer.sv ====
// post-termination top-off timer counting whole minutes
// assumes termination flag is already on the core clock
`timescale 1ns/1ps
module post_termination_timer #(
  parameter int unsigned CYCLES_PER_MIN = charger_cfg_pkg::MIN_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  topoff_if.timer tif
);
  import charger_cfg_pkg::*;
  logic [31:0] cycleCnt_reg;
  logic [5:0] minCnt_reg;
  logic [5:0] target;

  assign target = 6'(tif.sel * TOPOFF_STEP_MIN);

  // count pauses while termination drops; charge-off restarts from zero
  always_ff @(posedge core_clk) begin
    if (sys_rst || !tif.chargeOn) begin
      cycleCnt_reg <= '0;
      minCnt_reg <= '0;
      tif.done <= 1'b0;
    end else if (!tif.done && tif.termMet) begin
      if (minCnt_reg >= target) begin
        tif.done <= 1'b1; // R15
      end else if (cycleCnt_reg == 32'(CYCLES_PER_MIN - 1)) begin
        cycleCnt_reg <= '0;
        minCnt_reg <= minCnt_reg + 6'h01;
      end else begin
        cycleCnt_reg <= cycleCnt_reg + 32'h0000_0001;
      end
    end
  end

  AST_TOPOFF_NONE: assert property ( // R15
    @(posedge core_clk) disable iff (sys_rst)
    tif.sel == 2'h0 && tif.chargeOn && tif.termMet && !tif.done
    |=> tif.done || !$past(tif.chargeOn))
    else $error("top-off disabled but charge did not end");
endmodule

// ==== hw/charger_cfg_decode.sv ====
// turns raw field codes into clamped physical settings
// assumes codes come from registers on the same clock
`timescale 1ns/1ps
module charger_cfg_decode (
  // raw codes
  input wire logic [5:0] ichgCode,
  input wire logic [3:0] preCode,
  input wire logic [3:0] termCode,
  input wire logic [4:0] vregCode,
  input wire logic [2:0] sysMinCode,
  input wire logic batSel,
  input wire logic boostLimSel,
  // decoded settings
  output logic [charger_cfg_pkg::MV_W-1:0] ichgMa,
  output logic [charger_cfg_pkg::MV_W-1:0] preMa,
  output logic [charger_cfg_pkg::MV_W-1:0] termMa,
  output logic [charger_cfg_pkg::MV_W-1:0] vregMv,
  output logic [charger_cfg_pkg::MV_W-1:0] sysMinMv,
  output logic [charger_cfg_pkg::MV_W-1:0] batFallMv,
  output logic [charger_cfg_pkg::MV_W-1:0] boostLimMa
);
  import charger_cfg_pkg::*;
  logic [5:0] ichgC;
  logic [3:0] preC;
  logic [3:0] termC;
  logic [4:0] vregC;

  assign ichgC = (ichgCode > FAST_CHARGE_CURRENT_MAX) ? FAST_CHARGE_CURRENT_MAX : ichgCode; // R8
  assign preC = (preCode > ITAP_MAX) ? ITAP_MAX : preCode; // R10
  assign termC = (termCode > ITAP_MAX) ? ITAP_MAX : termCode; // R11
  assign vregC = (vregCode > CHARGE_VOLTAGE_MAX) ? CHARGE_VOLTAGE_MAX : vregCode; // R14
  assign ichgMa = MV_W'(ichgC) * CUR_LSB_MA; // R8
  assign preMa = MV_W'(preC) * CUR_LSB_MA + CUR_LSB_MA; // R10
  assign termMa = MV_W'(termC) * CUR_LSB_MA + CUR_LSB_MA; // R11
  // the special code sits below the clamp, so check it on the raw code
  assign vregMv = (vregCode == CHARGE_VOLTAGE_SPECIAL) ? CHARGE_VOLTAGE_SPECIAL_MV // R13
    : CHARGE_VOLTAGE_BASE_MV + MV_W'(vregC) * CHARGE_VOLTAGE_LSB_MV; // R12
  assign sysMinMv = SYSMIN_MV[sysMinCode]; // R4
  assign batFallMv = batSel ? BAT_FALL_LO_MV : BAT_FALL_HI_MV; // R5
  assign boostLimMa = boostLimSel ? BLIM_HI_MA : BLIM_LO_MA; // R6
endmodule

// ==== verification/serial_host_model.sv ====
// two-wire host model that reaches the bank's registers
// assumes one core clock; the data wire has a pull-up, the clock idles high
`timescale 1ns/1ps
module serial_host_model (
  // clock
  input wire logic core_clk,
  // wire levels
  output logic scl,
  output logic sda,
  // target drive
  input wire logic devOe,
  input wire logic devOut
);
  import charger_cfg_pkg::*;
  logic mLow;
  // a released wire floats high, never holds the last value
  assign sda = (mLow || (devOe && !devOut)) ? 1'b0 : 1'b1;
  initial begin
    scl = 1'b1;
    mLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // data settles mid-low, sampled mid-high: well clear of the sync delay
  task automatic bitIo(input logic b, output logic r);
    mLow <= !b;
    tick(6);
    scl <= 1'b1;
    tick(4);
    r = sda;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic byteIo(input logic [7:0] d, input logic ab,
                        output logic [7:0] r, output logic nk);
    for (int i = 7; i >= 0; i--) bitIo(d[i], r[i]);
    bitIo(ab, nk);
  endtask
  task automatic start();
    mLow <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(8);
    mLow <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    mLow <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(8);
    mLow <= 1'b0;
    tick(8);
  endtask
  // burst write from address a, n bytes taken from the top of d
  task automatic wr(input logic [7:0] a, input logic [39:0] d,
                    input int n, output logic [6:0] nk);
    logic [7:0] r;
    nk = '0;
    start();
    byteIo({DEV_ADDR, 1'b0}, 1'b1, r, nk[0]);
    byteIo(a, 1'b1, r, nk[1]);
    for (int k = 0; k < n; k++) byteIo(d[39-8*k -: 8], 1'b1, r, nk[2+k]);
    stop();
  endtask
  // burst read through a repeated start; last byte answered with nack
  task automatic rd(input logic [7:0] a, input int n,
                    output logic [31:0] d, output logic [6:0] nk);
    logic [7:0] r;
    logic x;
    nk = '0;
    d = '0;
    start();
    byteIo({DEV_ADDR, 1'b0}, 1'b1, r, nk[0]);
    byteIo(a, 1'b1, r, nk[1]);
    start();
    byteIo({DEV_ADDR, 1'b1}, 1'b1, r, nk[2]);
    for (int k = 0; k < n; k++) begin
      byteIo(8'hFF, logic'(k == n - 1), r, x);
      d[31-8*k -: 8] = r;
    end
    stop();
  endtask
endmodule

// ==== verification/charger_config_registers_bench.sv ====
// self-checking bench for the charger configuration bank
// assumes the host model above and a ten-cycle minute
`timescale 1ns/1ps
module charger_config_registers_bench;
  import charger_cfg_pkg::*;
  logic coreClk, sysRst, chargePinN, regReset, watchdogExpired, termMet;
  logic [4:0] inputLimitCode;
  logic scl, sda, sdaOut, sdaOe, chargeEnable, boostEnable, chargeDone;
  logic watchdogKick, lightLoadDisable, inputSwitchHighRes, rechargeSel;
  logic [MV_W-1:0] ichgMa, preMa, termMa, vregMv, sysMinMv, batFallMv;
  logic [MV_W-1:0] batRiseMv, boostLimMa;
  logic [7:0] expReg [REG_COUNT];
  logic [6:0] nk;
  logic [31:0] corner [4] = '{32'h3000_DD78, 32'h1033_CDC8,
    32'hEF3F_FFF8, 32'h7132_00C0};
  int numErrors, testsRun, seed, expKicks, n, lo;
  int kicks = 0;
  serial_host_model host_u (.core_clk(coreClk), .scl(scl), .sda(sda),
    .devOe(sdaOe), .devOut(sdaOut));
  charger_config_registers #(.CYCLES_PER_MIN(10)) dut_u (
    .core_clk(coreClk), .sys_rst(sysRst), .sclIn(scl), .sdaIn(sda),
    .sdaOut, .sdaOe, .chargePinN, .regReset, .watchdogExpired, .termMet,
    .inputLimitCode, .chargeEnable, .boostEnable, .chargeDone,
    .watchdogKick, .lightLoadDisable, .inputSwitchHighRes, .rechargeSel,
    .ichgMa, .preMa, .termMa, .vregMv, .sysMinMv, .batFallMv, .batRiseMv,
    .boostLimMa);
  initial begin
    coreClk = 1'b0;
    forever #25 coreClk = ~coreClk;
  end
  always @(posedge coreClk) if (watchdogKick === 1'b1) kicks <= kicks + 1;
  function automatic logic [12:0] curMa(input logic [5:0] c, mx,
                                        input logic [12:0] off);
    return 13'((c > mx ? mx : c) * CUR_LSB_MA) + off;
  endfunction
  function automatic logic [12:0] voltMv(input logic [4:0] c);
    if (c == CHARGE_VOLTAGE_SPECIAL) return CHARGE_VOLTAGE_SPECIAL_MV;
    return CHARGE_VOLTAGE_BASE_MV + 13'((c > CHARGE_VOLTAGE_MAX ? CHARGE_VOLTAGE_MAX : c) * CHARGE_VOLTAGE_LSB_MV);
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic checkState();
    logic [31:0] d;
    logic [7:0] r1, r2, r3, r4;
    {r1, r2, r3, r4} = {expReg[0], expReg[1], expReg[2], expReg[3]};
    host_u.rd(REG_FIRST, 4, d, nk);
    check("read acks", 32'(nk), 32'h0000_0000);
    check("readback", d, {r1, r2, r3, r4});
    check("flags", 32'({lightLoadDisable, boostEnable, rechargeSel,
      chargeEnable, inputSwitchHighRes}), 32'({r1[7], r1[5], r4[0],
      !chargePinN && r1[4] && !r1[5] && r2[5:0] != 6'h00,
      !r1[5] && !r2[6] && inputLimitCode < IIN_700_CODE}));
    check("ichgMa", 32'(ichgMa), 32'(curMa(r2[5:0], FAST_CHARGE_CURRENT_MAX, '0)));
    check("preMa", 32'(preMa),
      32'(curMa({2'h0, r3[7:4]}, {2'h0, ITAP_MAX}, CUR_LSB_MA)));
    check("termMa", 32'(termMa),
      32'(curMa({2'h0, r3[3:0]}, {2'h0, ITAP_MAX}, CUR_LSB_MA)));
    check("vregMv", 32'(vregMv), 32'(voltMv(r4[7:3])));
    check("sysMinMv", 32'(sysMinMv), 32'(SYSMIN_MV[r1[3:1]]));
    check("batMv", {3'h0, batFallMv, 3'h0, batRiseMv},
      {3'h0, r1[0] ? BAT_FALL_LO_MV : BAT_FALL_HI_MV, 3'h0,
      BAT_RISE_MV});
    check("boostLimMa", 32'(boostLimMa),
      32'(r2[7] ? BLIM_HI_MA : BLIM_LO_MA));
  endtask
  task automatic wrAll(input logic [31:0] v);
    host_u.wr(REG_FIRST, {v, 8'h5A}, 5, nk);
    // the fifth byte runs past the last register and is refused
    check("write acks", 32'(nk), 32'h0000_0040);
    {expReg[0], expReg[1], expReg[2], expReg[3]} = v;
    expReg[0] = expReg[0] & STORE_MASK[0];
    if (v[24+BIT_KICK]) expKicks++;
    repeat (8) @(posedge coreClk);
  endtask
  initial begin
    seed = 32'hbc0b;
    numErrors = 0;
    testsRun = 0;
    expKicks = 0;
    sysRst = 1'b1;
    chargePinN = 1'b1;
    regReset = 1'b0;
    watchdogExpired = 1'b0;
    termMet = 1'b0;
    inputLimitCode = 5'h00;
    expReg = REG_DEFAULT;
    repeat (2) @(posedge coreClk);
    sysRst <= 1'b0;
    repeat (4) @(posedge coreClk);
    checkState();
    $display("test defaults done");
    for (int i = 0; i < 10; i++) begin
      chargePinN <= 1'($random(seed));
      inputLimitCode <= 5'($random(seed));
      wrAll(i < 4 ? corner[i] : $random(seed));
      checkState();
    end
    check("kick pulses", 32'(kicks), 32'(expKicks));
    $display("test writes done");
    wrAll(32'hC545_DDA7);
    watchdogExpired <= 1'b1;
    @(posedge coreClk);
    watchdogExpired <= 1'b0;
    for (int k = 0; k < REG_COUNT; k++)
      expReg[k] = (expReg[k] & ~WD_MASK[k]) | (REG_DEFAULT[k] & WD_MASK[k]);
    repeat (4) @(posedge coreClk);
    checkState();
    regReset <= 1'b1;
    @(posedge coreClk);
    regReset <= 1'b0;
    expReg = REG_DEFAULT;
    repeat (4) @(posedge coreClk);
    checkState();
    $display("test restore done");
    foreach (corner[k]) begin
      host_u.wr(8'(k == 0 ? 0 : 4 + k), 40'h00_0000_0000, 1, nk);
      check("undefined address", 32'(nk[1]), 32'h0000_0001);
    end
    checkState();
    $display("test undefined done");
    for (int s = 0; s < 4; s++) begin
      expReg[3][2:1] = 2'(s);
      host_u.wr(8'h04, {expReg[3], 32'h0000_0000}, 1, nk);
      chargePinN <= 1'b0;
      repeat (6) @(posedge coreClk);
      check("charging", 32'(chargeEnable), 32'h0000_0001);
      termMet <= 1'b1;
      n = 0;
      lo = s == 0 ? 2 : s * 15 * 10;
      // look at the flag mid-cycle, once it has settled
      while (chargeDone !== 1'b1 && n < 1000) begin
        @(negedge coreClk);
        n++;
      end
      if (n >= 1000) begin
        numErrors++;
        testDone();
      end
      check("topoff time", 32'(n >= lo - 1 && n <= lo + 4), 32'h1);
      termMet <= 1'b0;
      chargePinN <= 1'b1;
      repeat (6) @(posedge coreClk);
      check("done cleared", 32'(chargeDone), 32'h0000_0000);
    end
    $display("test topoff done");
    testDone();
  end
endmodule
